/* File: acrd_defs.vh */
`ifndef ACRD_DEFS_VH
`define ACRD_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ACRD_OFS_RATE_RATIO     8'h5B
`define ACRD_OFS_BCLK_HIGH      8'h5C
`define ACRD_OFS_BCLK_LOW       8'h5D
`define ACRD_OFS_FLAGS          8'h5E

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ACRD_RATE_MSB           6
`define ACRD_RATE_LSB           4
`define ACRD_RATIO_MSB          3
`define ACRD_RATIO_LSB          0
`define ACRD_BCLK_LOW_BIT       7
`define ACRD_FLAG_HALT_BIT      6
`define ACRD_FLAG_PLL_BIT       5
`define ACRD_FLAG_ABSENT_BIT    4
`define ACRD_FLAG_COMBO_BIT     3
`define ACRD_FLAG_MCLK_BIT      2
`define ACRD_FLAG_BCLK_BIT      1
`define ACRD_FLAG_RATE_BIT      0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ACRD_RST_BYTE           8'h00
`define ACRD_RST_RATE           3'h0
`define ACRD_RST_RATIO          4'h0
`define ACRD_RST_BCLK           9'h000

// ----------------------------------------------------------------------
// Rate and ratio encodings
// ----------------------------------------------------------------------
`define ACRD_RATE_ERR           3'h0
`define ACRD_RATE_8K            3'h1
`define ACRD_RATE_16K           3'h2
`define ACRD_RATE_48K           3'h3
`define ACRD_RATE_96K           3'h4
`define ACRD_RATE_192K          3'h5
`define ACRD_RATE_384K          3'h6
`define ACRD_RATIO_ERR          4'h0
`define ACRD_RATIO_128FS        4'h4

// ----------------------------------------------------------------------
// Frame period windows in clk_i cycles (200 MHz)
// ----------------------------------------------------------------------
`define ACRD_P384_MIN           16'h01F4
`define ACRD_P384_MAX           16'h0221
`define ACRD_P192_MIN           16'h03E8
`define ACRD_P192_MAX           16'h0488
`define ACRD_P96_MIN            16'h07D0
`define ACRD_P96_MAX            16'h0910
`define ACRD_P48_MIN            16'h0FA0
`define ACRD_P48_MAX            16'h1900
`define ACRD_P16_MIN            16'h2EE0
`define ACRD_P16_MAX            16'h32C8
`define ACRD_P8_MIN             16'h5DC0
`define ACRD_P8_MAX             16'h6590

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ACRD_CLK_PERIOD_NS      5
`define ACRD_FAST_WIN_NS        1000
`define ACRD_MCLK_MAX_MHZ       50
`define ACRD_HALT_NS            10240
`define ACRD_ABSENT_NS          200000
`define ACRD_RATIO_TOL          12'h002
`define ACRD_BCLK_MIN           9'h020
`define ACRD_BCLK_MAX           9'h100
`define ACRD_LR_LOW_MIN         9'h005

`endif

/* File: acrd_sync_edge.v */
// ----------------------------------------------------------------------
// Two-stage synchroniser with a rising-edge detector behind it.
// ----------------------------------------------------------------------
module acrd_sync_edge (
   // Clock and reset
   input  wire clk_i,
   input  wire reset_i,
   // Asynchronous input and results
   input  wire din_i,
   output wire level_o,
   output wire rise_o
);

   reg meta_r;
   reg sync_r;
   reg prev_r;

   // Only sync_r reads meta_r; the edge logic looks at later stages.
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= din_i;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign level_o = sync_r;
   assign rise_o  = sync_r & ~prev_r;

endmodule

/* File: acrd_regfile.v */
`include "acrd_defs.vh"

// ----------------------------------------------------------------------
// Register file: read-only status plus the writable reserved bits.
// ----------------------------------------------------------------------
module acrd_regfile (
   // Clock and reset
   input  wire       clk_i,
   input  wire       reset_i,
   // Register port
   input  wire [7:0] reg_addr_i,
   input  wire       reg_wr_i,
   input  wire       reg_rd_i,
   input  wire [7:0] reg_wdata_i,
   output reg  [7:0] reg_rdata_o,
   // Status from the measurement logic
   input  wire [2:0] rate_i,
   input  wire [3:0] ratio_i,
   input  wire [8:0] bclk_count_i,
   input  wire [6:0] flags_i
);

   reg       rr_top_r;
   reg [6:0] bh_rsv_r;
   reg [6:0] bl_rsv_r;
   reg       fl_top_r;
   reg [7:0] rdata_nxt;

   // Writes only land in the reserved read/write bits; status bits ignore them.
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rr_top_r <= 1'b0;
         bh_rsv_r <= 7'h00;
         bl_rsv_r <= 7'h00;
         fl_top_r <= 1'b0;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            `ACRD_OFS_RATE_RATIO: rr_top_r <= reg_wdata_i[7];
            `ACRD_OFS_BCLK_HIGH:  bh_rsv_r <= reg_wdata_i[7:1];
            `ACRD_OFS_BCLK_LOW:   bl_rsv_r <= reg_wdata_i[6:0];
            `ACRD_OFS_FLAGS:      fl_top_r <= reg_wdata_i[7];
            default: begin
            end
         endcase
      end
   end

   always @* begin
      case (reg_addr_i)
         `ACRD_OFS_RATE_RATIO: rdata_nxt = {rr_top_r, rate_i, ratio_i};
         `ACRD_OFS_BCLK_HIGH:  rdata_nxt = {bh_rsv_r, bclk_count_i[8]};
         `ACRD_OFS_BCLK_LOW:   rdata_nxt = {bclk_count_i[7], bl_rsv_r};
         `ACRD_OFS_FLAGS:      rdata_nxt = {fl_top_r, flags_i};
         default:              rdata_nxt = `ACRD_RST_BYTE;
      endcase
   end

   // Read data is held until the next read strobe.
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         reg_rdata_o <= `ACRD_RST_BYTE;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rdata_nxt;
      end
   end

endmodule

/* File: acrd_detector.v */
`include "acrd_defs.vh"

module acrd_detector #(
   parameter ABSENT_CYCLES = `ACRD_ABSENT_NS / `ACRD_CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire       clk_i,
   input  wire       reset_i,
   // Serial audio clocks from the source
   input  wire       mclk_i,
   input  wire       bclk_i,
   input  wire       lrclk_i,
   // PLL state
   input  wire       pll_enable_i,
   input  wire       pll_lock_i,
   // Register port
   input  wire [7:0] reg_addr_i,
   input  wire       reg_wr_i,
   input  wire       reg_rd_i,
   input  wire [7:0] reg_wdata_i,
   output wire [7:0] reg_rdata_o
);

   // ----------------------------------------------------------------------
   // Derived cycle counts
   // ----------------------------------------------------------------------
   localparam        WIN_N      = `ACRD_FAST_WIN_NS / `ACRD_CLK_PERIOD_NS;
   localparam        EDGE_N     = `ACRD_MCLK_MAX_MHZ * `ACRD_FAST_WIN_NS / 1000;
   localparam        HALT_N     = `ACRD_HALT_NS / `ACRD_CLK_PERIOD_NS;
   localparam [7:0]  FAST_WIN   = WIN_N[7:0];
   localparam [7:0]  FAST_EDGES = EDGE_N[7:0];
   localparam [11:0] HALT_CYC   = HALT_N[11:0];
   localparam [17:0] ABSENT_CYC = ABSENT_CYCLES[17:0];

   // ----------------------------------------------------------------------
   // Classification functions
   // ----------------------------------------------------------------------
   function [2:0] rate_class;
      input [15:0] p;
      begin
         if (p >= `ACRD_P384_MIN && p <= `ACRD_P384_MAX)
            rate_class = `ACRD_RATE_384K;
         else if (p >= `ACRD_P192_MIN && p <= `ACRD_P192_MAX)
            rate_class = `ACRD_RATE_192K;
         else if (p >= `ACRD_P96_MIN && p <= `ACRD_P96_MAX)
            rate_class = `ACRD_RATE_96K;
         else if (p >= `ACRD_P48_MIN && p <= `ACRD_P48_MAX)
            rate_class = `ACRD_RATE_48K;
         else if (p >= `ACRD_P16_MIN && p <= `ACRD_P16_MAX)
            rate_class = `ACRD_RATE_16K;
         else if (p >= `ACRD_P8_MIN && p <= `ACRD_P8_MAX)
            rate_class = `ACRD_RATE_8K;
         else
            rate_class = `ACRD_RATE_ERR;
      end
   endfunction

   function near;
      input [11:0] n;
      input [11:0] nominal;
      begin
         near = (n + `ACRD_RATIO_TOL >= nominal) && (n <= nominal + `ACRD_RATIO_TOL);
      end
   endfunction

   // Master edges are counted at the system rate, so a small tolerance
   // absorbs the sampling jitter at either end of the frame.
   function [3:0] ratio_class;
      input [11:0] n;
      begin
         if (near(n, 12'h020))      ratio_class = 4'h1;
         else if (near(n, 12'h030)) ratio_class = 4'h2;
         else if (near(n, 12'h040)) ratio_class = 4'h3;
         else if (near(n, 12'h080)) ratio_class = 4'h4;
         else if (near(n, 12'h0C0)) ratio_class = 4'h5;
         else if (near(n, 12'h100)) ratio_class = 4'h6;
         else if (near(n, 12'h180)) ratio_class = 4'h7;
         else if (near(n, 12'h200)) ratio_class = 4'h8;
         else if (near(n, 12'h300)) ratio_class = 4'h9;
         else if (near(n, 12'h400)) ratio_class = 4'hA;
         else if (near(n, 12'h480)) ratio_class = 4'hB;
         else if (near(n, 12'h600)) ratio_class = 4'hC;
         else if (near(n, 12'h800)) ratio_class = 4'hD;
         else                       ratio_class = `ACRD_RATIO_ERR;
      end
   endfunction

   // ----------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------
   wire mclk_rise;
   wire bclk_lvl;
   wire bclk_rise;
   wire lr_lvl;
   wire lr_rise;

   acrd_sync_edge u_sync_mclk (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .din_i   (mclk_i),
      .level_o (),
      .rise_o  (mclk_rise)
   );

   acrd_sync_edge u_sync_bclk (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .din_i   (bclk_i),
      .level_o (bclk_lvl),
      .rise_o  (bclk_rise)
   );

   acrd_sync_edge u_sync_lr (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .din_i   (lrclk_i),
      .level_o (lr_lvl),
      .rise_o  (lr_rise)
   );

   // ----------------------------------------------------------------------
   // Per-frame counters
   // ----------------------------------------------------------------------
   reg  [15:0] period_r;
   reg  [11:0] mclk_cnt_r;
   reg  [8:0]  bclk_cnt_r;
   reg  [8:0]  lr_low_cnt_r;
   reg         seen_frame_r;
   wire        period_sat = (period_r == 16'hFFFF);

   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         period_r     <= 16'h0000;
         mclk_cnt_r   <= 12'h000;
         bclk_cnt_r   <= 9'h000;
         lr_low_cnt_r <= 9'h000;
         seen_frame_r <= 1'b0;
      end else if (lr_rise) begin
         period_r     <= 16'h0001;
         mclk_cnt_r   <= {11'h000, mclk_rise};
         bclk_cnt_r   <= {8'h00, bclk_rise};
         lr_low_cnt_r <= 9'h000;
         seen_frame_r <= 1'b1;
      end else begin
         if (!period_sat)
            period_r <= period_r + 16'h0001;
         if (mclk_rise && mclk_cnt_r != 12'hFFF)
            mclk_cnt_r <= mclk_cnt_r + 12'h001;
         if (bclk_rise && bclk_cnt_r != 9'h1FF)
            bclk_cnt_r <= bclk_cnt_r + 9'h001;
         if (bclk_rise && !lr_lvl && lr_low_cnt_r != 9'h1FF)
            lr_low_cnt_r <= lr_low_cnt_r + 9'h001;
         if (period_sat)
            seen_frame_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Frame results, latched on each frame start that ends a whole frame
   // ----------------------------------------------------------------------
   reg  [2:0] rate_r;
   reg  [3:0] ratio_r;
   reg  [8:0] bclk_res_r;
   reg        bclk_stable_r;
   reg        lr_low_short_r;
   wire       frame_done = lr_rise && seen_frame_r;

   // Nothing here waits for software: each frame start that ends a whole frame refreshes the fields.
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rate_r         <= `ACRD_RST_RATE;
         ratio_r        <= `ACRD_RST_RATIO;
         bclk_res_r     <= `ACRD_RST_BCLK;
         bclk_stable_r  <= 1'b0;
         lr_low_short_r <= 1'b0;
      end else if (frame_done) begin
         rate_r         <= rate_class(period_r);
         ratio_r        <= ratio_class(mclk_cnt_r);
         bclk_res_r     <= bclk_cnt_r;
         bclk_stable_r  <= (bclk_cnt_r == bclk_res_r);
         lr_low_short_r <= (lr_low_cnt_r <= `ACRD_LR_LOW_MIN);
      end else if (period_sat) begin
         rate_r        <= `ACRD_RATE_ERR;
         ratio_r       <= `ACRD_RATIO_ERR;
         bclk_res_r    <= `ACRD_RST_BCLK;
         bclk_stable_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Master clock speed and presence
   // ----------------------------------------------------------------------
   reg  [7:0]  win_r;
   reg  [7:0]  win_edges_r;
   reg         too_fast_r;
   reg  [11:0] idle_r;
   reg         halted_r;
   wire        win_end = (win_r == FAST_WIN - 8'h01);

   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         win_r       <= 8'h00;
         win_edges_r <= 8'h00;
         too_fast_r  <= 1'b0;
      end else if (win_end) begin
         win_r       <= 8'h00;
         win_edges_r <= 8'h00;
         too_fast_r  <= (win_edges_r + {7'h00, mclk_rise}) >= FAST_EDGES;
      end else begin
         win_r <= win_r + 8'h01;
         if (mclk_rise)
            win_edges_r <= win_edges_r + 8'h01;
      end
   end

   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         idle_r   <= 12'h000;
         halted_r <= 1'b0;
      end else if (mclk_rise) begin
         idle_r   <= 12'h000;
         halted_r <= 1'b0;
      end else if (idle_r >= HALT_CYC - 12'h001) begin
         halted_r <= 1'b1;
      end else begin
         idle_r <= idle_r + 12'h001;
      end
   end

   // ----------------------------------------------------------------------
   // Serial clocks held low
   // ----------------------------------------------------------------------
   reg [17:0] low_r;
   reg        absent_r;

   // A clock stuck high is not reported here, only both lines held low.
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         low_r    <= 18'h00000;
         absent_r <= 1'b0;
      end else if (bclk_lvl || lr_lvl) begin
         low_r    <= 18'h00000;
         absent_r <= 1'b0;
      end else if (low_r >= ABSENT_CYC - 18'h00001) begin
         absent_r <= 1'b1;
      end else begin
         low_r <= low_r + 18'h00001;
      end
   end

   // ----------------------------------------------------------------------
   // Error flag byte
   // ----------------------------------------------------------------------
   reg  [6:0] flags_r;
   reg  [6:0] flags_nxt;
   wire       ratio_low = (ratio_r != `ACRD_RATIO_ERR) && (ratio_r < `ACRD_RATIO_128FS);
   wire       pll_off   = !pll_enable_i;

   always @* begin
      flags_nxt = 7'h00;
      flags_nxt[`ACRD_FLAG_HALT_BIT]   = halted_r;
      flags_nxt[`ACRD_FLAG_PLL_BIT]    = pll_off || !pll_lock_i;
      flags_nxt[`ACRD_FLAG_ABSENT_BIT] = absent_r;
      flags_nxt[`ACRD_FLAG_COMBO_BIT]  = (rate_r == `ACRD_RATE_ERR) ||
                                         (ratio_r == `ACRD_RATIO_ERR) ||
                                         too_fast_r ||
                                         (pll_off && ratio_low);
      flags_nxt[`ACRD_FLAG_MCLK_BIT]   = (ratio_r == `ACRD_RATIO_ERR) || halted_r ||
                                         too_fast_r || lr_low_short_r;
      flags_nxt[`ACRD_FLAG_BCLK_BIT]   = !bclk_stable_r ||
                                         (bclk_res_r < `ACRD_BCLK_MIN) ||
                                         (bclk_res_r > `ACRD_BCLK_MAX);
      flags_nxt[`ACRD_FLAG_RATE_BIT]   = (rate_r == `ACRD_RATE_ERR);
   end

   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         flags_r <= 7'h00;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------
   acrd_regfile u_regs (
      .clk_i        (clk_i),
      .reset_i      (reset_i),
      .reg_addr_i   (reg_addr_i),
      .reg_wr_i     (reg_wr_i),
      .reg_rd_i     (reg_rd_i),
      .reg_wdata_i  (reg_wdata_i),
      .reg_rdata_o  (reg_rdata_o),
      .rate_i       (rate_r),
      .ratio_i      (ratio_r),
      .bclk_count_i (bclk_res_r),
      .flags_i      (flags_r)
   );

endmodule

/* File: acrd_chk.sv */
// ----------------------------------------------------------------------
// Port-level checks on the clock ratio detector.
// ----------------------------------------------------------------------
module acrd_chk #(
   parameter ABSENT_CYCLES = 40000
) (
   // Clock and reset
   input wire       clk_i,
   input wire       reset_i,
   // Audio clocks and PLL state
   input wire       mclk_i,
   input wire       bclk_i,
   input wire       lrclk_i,
   input wire       pll_enable_i,
   input wire       pll_lock_i,
   // Register port
   input wire [7:0] reg_addr_i,
   input wire       reg_wr_i,
   input wire       reg_rd_i,
   input wire [7:0] reg_wdata_i,
   input wire [7:0] reg_rdata_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] since_mclk_r;
   logic [15:0] low_cnt_r;
   logic [1:0]  up_r;
   logic        mclk_q_r;
   wire         rd_flags = reg_rd_i && reg_addr_i == 8'h5E;

   // These counters watch the raw pins, which lead the synchronised copies by a few
   // cycles, so every bound below carries a small margin.
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         mclk_q_r     <= 1'b0;
         since_mclk_r <= 16'h0000;
         low_cnt_r    <= 16'h0000;
         up_r         <= 2'h0;
      end else begin
         mclk_q_r     <= mclk_i;
         since_mclk_r <= (mclk_i && !mclk_q_r) ? 16'h0000 : since_mclk_r + 16'h0001;
         low_cnt_r    <= (bclk_i || lrclk_i) ? 16'h0000 : low_cnt_r + 16'h0001;
         up_r         <= up_r + {1'b0, up_r != 2'h3};
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   sequence s_wr_rsv; reg_wr_i && !reg_rd_i && reg_addr_i == 8'h5B; endsequence
   sequence s_rd_rsv; reg_rd_i && !reg_wr_i && reg_addr_i == 8'h5B; endsequence

   property p_rst_zero; $fell(reset_i) |-> reg_rdata_o == 8'h00; endproperty
   property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
   property p_unmapped;
      reg_rd_i && (reg_addr_i < 8'h5B || reg_addr_i > 8'h5E) |=> reg_rdata_o == 8'h00;
   endproperty
   property p_rate_code; reg_rd_i && reg_addr_i == 8'h5B |=> reg_rdata_o[6:4] <= 3'h6; endproperty
   property p_ratio_code; reg_rd_i && reg_addr_i == 8'h5B |=> reg_rdata_o[3:0] <= 4'hD; endproperty
   property p_rsv_rw; s_wr_rsv ##1 s_rd_rsv |=> reg_rdata_o[7] == $past(reg_wdata_i[7], 2); endproperty
   property p_pll_flag;
      rd_flags && up_r == 2'h3 |=> reg_rdata_o[5] == !($past(pll_enable_i, 2) && $past(pll_lock_i, 2));
   endproperty
   property p_halt_set; rd_flags && since_mclk_r > 16'h080C |=> reg_rdata_o[6]; endproperty
   property p_halt_clr;
      rd_flags && since_mclk_r >= 16'h0008 && since_mclk_r <= 16'h0064 |=> !reg_rdata_o[6];
   endproperty
   property p_absent; rd_flags && low_cnt_r > ABSENT_CYCLES + 8 |=> reg_rdata_o[4]; endproperty

   a_rst_zero: assert property (p_rst_zero) else $error("read data not zero after reset");
   a_hold: assert property (p_hold) else $error("read data moved without a read");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_rate_code: assert property (p_rate_code) else $error("rate class code undefined");
   a_ratio_code: assert property (p_ratio_code) else $error("ratio code undefined");
   a_rsv_rw: assert property (p_rsv_rw) else $error("spare bit not written");
   a_pll_flag: assert property (p_pll_flag) else $error("PLL flag wrong");
   a_halt_set: assert property (p_halt_set) else $error("halt flag not set");
   a_halt_clr: assert property (p_halt_clr) else $error("halt flag not cleared");
   a_absent: assert property (p_absent) else $error("absent flag not set");
endmodule

bind acrd_detector acrd_chk #(.ABSENT_CYCLES(ABSENT_CYCLES)) i_chk (
   .clk_i(clk_i), .reset_i(reset_i), .mclk_i(mclk_i), .bclk_i(bclk_i), .lrclk_i(lrclk_i),
   .pll_enable_i(pll_enable_i), .pll_lock_i(pll_lock_i), .reg_addr_i(reg_addr_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o));

/* File: acrd_src_model.sv */
// ----------------------------------------------------------------------
// Serial audio source: master, bit and frame clocks.
// ----------------------------------------------------------------------
module acrd_src_model (
   // Control from the bench
   input  wire        run_i,
   input  wire [9:0]  bits_i,
   input  wire [15:0] mclk_half_i,
   // Clocks towards the detector
   output logic       mclk_o,
   output logic       bclk_o,
   output logic       lrclk_o
);
   timeunit 1ns;
   timeprecision 100ps;
   int frame_len;

   initial mclk_o = 1'b0;

   // A zero half period stops the master clock; 10 ns is the deliberate over-speed case.
   always begin
      if (mclk_half_i == 16'h0000) begin
         mclk_o = 1'b0;
         #1;
      end else begin
         #(mclk_half_i) mclk_o = ~mclk_o;
      end
   end

   // Frame length is latched per frame so a change never splits one; idle lines sit low.
   always begin
      if (!run_i) begin
         bclk_o = 1'b0;
         lrclk_o = 1'b0;
         #10;
      end else begin
         frame_len = bits_i;
         for (int i = 0; i < frame_len; i++) begin
            lrclk_o = (i < frame_len / 2);
            bclk_o = 1'b0;
            #80;
            bclk_o = 1'b1;
            #80;
         end
      end
   end
endmodule

/* File: audio_clock_ratio_detector_tb.sv */
module audio_clock_ratio_detector_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int ABSENT = 2000;
   logic        clk_i;
   logic        reset_i;
   logic        pll_enable_i;
   logic        pll_lock_i;
   logic        reg_wr_i;
   logic        reg_rd_i;
   logic [7:0]  reg_addr_i;
   logic [7:0]  reg_wdata_i;
   wire  [7:0]  reg_rdata_o;
   wire         mclk_w;
   wire         bclk_w;
   wire         lrclk_w;
   logic        src_run = 1'b0;
   logic [9:0]  src_bits = 10'h040;
   logic [15:0] src_half = 16'h0000;
   int          error_cnt;
   int          checks;

   acrd_detector #(.ABSENT_CYCLES(ABSENT)) i_dut (
      .clk_i(clk_i), .reset_i(reset_i), .mclk_i(mclk_w), .bclk_i(bclk_w), .lrclk_i(lrclk_w),
      .pll_enable_i(pll_enable_i), .pll_lock_i(pll_lock_i), .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o));
   acrd_src_model i_src (.run_i(src_run), .bits_i(src_bits), .mclk_half_i(src_half),
      .mclk_o(mclk_w), .bclk_o(bclk_w), .lrclk_o(lrclk_w));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   task give_verdict;
      if (error_cnt == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Tasks start and end on a falling edge, so a write can be followed at once by a read.
   task wr(input logic [7:0] a, input logic [7:0] v);
      reg_addr_i = a;
      reg_wdata_i = v;
      reg_wr_i = 1'b1;
      @(negedge clk_i);
      reg_wr_i = 1'b0;
   endtask

   task rc(input string name, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(negedge clk_i);
      reg_rd_i = 1'b0;
      chk(name, reg_rdata_o & m, e);
      @(negedge clk_i);
   endtask

   task do_reset;
      reset_i = 1'b1;
      repeat (6) @(negedge clk_i);
      reset_i = 1'b0;
   endtask

   task t_reset_vals;
      rc("rate_ratio", 8'h5B, 8'hFF, 8'h00);
      rc("bclk_high", 8'h5C, 8'hFF, 8'h00);
      rc("bclk_low", 8'h5D, 8'hFF, 8'h00);
      rc("flags", 8'h5E, 8'hFF, 8'h0F);
      rc("unmapped_5a", 8'h5A, 8'hFF, 8'h00);
      rc("unmapped_5f", 8'h5F, 8'hFF, 8'h00);
   endtask

   task t_spare_bits;
      static logic [7:0] a[4] = '{8'h5B, 8'h5C, 8'h5D, 8'h5E};
      static logic [7:0] m[4] = '{8'h80, 8'hFE, 8'h7F, 8'h80};
      static logic [7:0] f[4] = '{8'hFF, 8'hFF, 8'hFF, 8'h80};
      for (int i = 0; i < 4; i++) begin
         wr(a[i], 8'hFF);
         rc("spare_set", a[i], f[i], m[i]);
         wr(a[i], 8'h00);
         rc("spare_clr", a[i], f[i], 8'h00);
      end
   endtask

   // Waits the old frame out, then two whole frames of 32 clk cycles per bit.
   task t_stream(input logic [9:0] bits, input logic [15:0] half, input logic [7:0] e5b,
                 input logic [7:0] ehi, input logic [7:0] elo, input logic [7:0] e5e);
      src_bits = bits;
      src_half = half;
      src_run = 1'b1;
      repeat (bits * 96 + 200) @(negedge clk_i);
      rc("rate_ratio", 8'h5B, 8'hFF, e5b);
      rc("count_bit8", 8'h5C, 8'h01, ehi);
      rc("count_bit7", 8'h5D, 8'h80, elo);
      rc("flags", 8'h5E, 8'hFF, e5e);
   endtask

   task t_pll_off;
      pll_enable_i = 1'b0;
      repeat (4) @(negedge clk_i);
      rc("pll_off", 8'h5E, 8'hFF, 8'h28);
      pll_enable_i = 1'b1;
      pll_lock_i = 1'b0;
      repeat (4) @(negedge clk_i);
      rc("pll_unlocked", 8'h5E, 8'hFF, 8'h20);
      pll_lock_i = 1'b1;
   endtask

   task t_halt;
      src_run = 1'b0;
      src_half = 16'h0000;
      // The source finishes its current frame first, which can last 8192 cycles.
      repeat (ABSENT + 10400) @(negedge clk_i);
      rc("halt_absent", 8'h5E, 8'h50, 8'h50);
      src_half = 16'h0050;
      repeat (60) @(negedge clk_i);
      rc("mclk_back", 8'h5E, 8'h40, 8'h00);
      src_run = 1'b1;
      repeat (20) @(negedge clk_i);
      rc("serial_back", 8'h5E, 8'h10, 8'h00);
   endtask

   initial begin
      reset_i = 1'b1;
      pll_enable_i = 1'b1;
      pll_lock_i = 1'b1;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_addr_i = 8'h00;
      reg_wdata_i = 8'h00;
      error_cnt = 0;
      checks = 0;
      do_reset();
      t_reset_vals();
      t_spare_bits();
      t_stream(10'h010, 16'h0014, 8'h63, 8'h00, 8'h00, 8'h02);
      t_stream(10'h040, 16'h0014, 8'h46, 8'h00, 8'h00, 8'h00);
      t_stream(10'h040, 16'h000A, 8'h48, 8'h00, 8'h00, 8'h0C);
      t_stream(10'h040, 16'h0050, 8'h43, 8'h00, 8'h00, 8'h00);
      t_pll_off();
      t_stream(10'h080, 16'h0014, 8'h38, 8'h00, 8'h80, 8'h00);
      t_stream(10'h100, 16'h0014, 8'h0A, 8'h01, 8'h00, 8'h09);
      t_halt();
      do_reset();
      t_reset_vals();
      give_verdict();
   end
endmodule
